// file: include/source_match_control_pkg.sv
// constants for source-match enables and automatic pending decision
package source_match_pkg;

    ////////////////////////////////////////////////////////////////////////
    // table sizes
    localparam int SHORT_ENTRIES = 24;
    localparam int LONG_ENTRIES = 12;
    localparam int LONG_PER_BYTE = 4;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [29:0] IDX_FILTER = 30'h0000_6180;
    localparam logic [29:0] IDX_CTRL = 30'h0000_6182;
    localparam logic [29:0] IDX_SHORT0 = 30'h0000_6183;
    localparam logic [29:0] IDX_SHORT1 = 30'h0000_6184;
    localparam logic [29:0] IDX_SHORT2 = 30'h0000_6185;
    localparam logic [29:0] IDX_LONG0 = 30'h0000_6186;
    localparam logic [29:0] IDX_LONG1 = 30'h0000_6187;
    localparam logic [29:0] IDX_LONG2 = 30'h0000_6188;
    localparam logic [29:0] IDX_STATUS = 30'h0000_61F0;
    localparam logic [29:0] IDX_COUNT = 30'h0000_61F1;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int FILTER_EN_BIT = 0;
    localparam int MATCH_EN_BIT = 0;
    localparam int AUTO_PENDING_BIT = 1;
    localparam int DREQ_ONLY_BIT = 2;
    localparam int CTRL_W = 3;
    localparam int ST_PENDING_BIT = 0;
    localparam int ST_SHORT_BIT = 1;
    localparam int ST_LONG_BIT = 2;
    localparam int ST_BYPASS_BIT = 3;
    localparam int ST_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic FILTER_RST = 1'h1;
    localparam logic [2:0] CTRL_RST = 3'h7;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;

endpackage

// file: tb/source_match_auto_pending_flag_enable_chk.sv
// assertion checker for the source-match register bank
module source_match_auto_pending_flag_enable_chk
    import source_match_pkg::*;
(
    input logic CLK,
    input logic RST_N,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [31:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [3:0] PSTRB,
    input logic [31:0] PRDATA,
    input logic FRAME_VALID,
    input logic [SHORT_ENTRIES-1:0] SHORT_HIT,
    input logic [SHORT_ENTRIES-1:0] SHORT_PEND_MASK,
    input logic [LONG_ENTRIES-1:0] LONG_HIT,
    input logic [LONG_ENTRIES-1:0] LONG_PEND_MASK,
    input logic FILTER_EN,
    input logic [SHORT_ENTRIES-1:0] SHORT_ENABLE,
    input logic [LONG_ENTRIES-1:0] LONG_ENABLE,
    input logic ACK_PENDING,
    input logic ACK_PENDING_VALID
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////
    wire logic wr = PSEL && PENABLE && PWRITE && PSTRB[0];
    wire logic rd = PSEL && PENABLE && !PWRITE;
    wire logic hit = |(SHORT_HIT & SHORT_ENABLE & SHORT_PEND_MASK)
        | |(LONG_HIT & LONG_ENABLE & LONG_PEND_MASK);
    wire logic [3:0] lw = {PWDATA[6], PWDATA[4], PWDATA[2], PWDATA[0]};
    wire logic [7:0] ld = {{2{LONG_ENABLE[3]}}, {2{LONG_ENABLE[2]}},
        {2{LONG_ENABLE[1]}}, {2{LONG_ENABLE[0]}}};
    ////////////////////////////////////////
    pulse_after_frame_a: assert property (FRAME_VALID |=> ACK_PENDING_VALID)
        else $error("no decision pulse after frame");
    no_stray_pulse_a: assert property (!FRAME_VALID |=> !ACK_PENDING_VALID)
        else $error("decision pulse without frame");
    filter_off_a: assert property (FRAME_VALID && !FILTER_EN |=> !ACK_PENDING)
        else $error("pending set with filtering off");
    no_hit_a: assert property (FRAME_VALID && !hit |=> !ACK_PENDING)
        else $error("pending set without qualified hit");
    pending_hold_a: assert property (!ACK_PENDING_VALID |-> $stable(ACK_PENDING))
        else $error("pending changed between decisions");
    short_write_a: assert property (wr && PADDR == {IDX_SHORT0, 2'b00}
        |=> SHORT_ENABLE[7:0] == $past(PWDATA[7:0])) else $error("short byte not stored");
    long_write_a: assert property (wr && PADDR == {IDX_LONG0, 2'b00}
        |=> LONG_ENABLE[3:0] == $past(lw)) else $error("long enables not from even bits");
    long_read_a: assert property (rd && PADDR == {IDX_LONG0, 2'b00}
        |-> PRDATA[7:0] == ld) else $error("long read not duplicated");
    reset_masks_a: assert property ($rose(RST_N)
        |-> SHORT_ENABLE == 24'h0 && LONG_ENABLE == 12'h0 && FILTER_EN)
        else $error("enable masks not cleared by reset");
endmodule

bind source_match_auto_pending_flag_enable_ctrl source_match_auto_pending_flag_enable_chk source_match_auto_pending_flag_enable_chk_inst (
    .CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .FRAME_VALID,
    .SHORT_HIT, .SHORT_PEND_MASK, .LONG_HIT, .LONG_PEND_MASK, .FILTER_EN, .SHORT_ENABLE,
    .LONG_ENABLE, .ACK_PENDING, .ACK_PENDING_VALID);

// file: tb/tb_top.sv
// self-checking bench for the source-match register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import source_match_pkg::*;
    logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, r, lfsr_q = 32'h0000_001E;
    logic [3:0] PSTRB = 4'hF;
    logic PREADY, PSLVERR, FRAME_VALID = 0, FRAME_IS_DATA_REQ = 0, e, FILTER_EN;
    logic ACK_PENDING, ACK_PENDING_VALID, filt = 1;
    logic [23:0] SHORT_HIT = 24'h0, SHORT_PEND_MASK = 24'h0, SHORT_ENABLE;
    logic [11:0] LONG_HIT = 12'h0, LONG_PEND_MASK = 12'h0, LONG_ENABLE;
    logic [7:0] sh [3] = '{8'h00, 8'h00, 8'h00};
    logic [3:0] lg [3] = '{4'h0, 4'h0, 4'h0};
    logic [2:0] ctl = 3'h7;
    logic [7:0] pc = 8'h00;
    logic [3:0] st = 4'h0;
    int errors = 0, checks_done = 0, k, n;
    source_match_auto_pending_flag_enable_ctrl source_match_auto_pending_flag_enable_ctrl_inst (.CLK, .RST_N, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR, .FRAME_VALID,
        .FRAME_IS_DATA_REQ, .SHORT_HIT, .SHORT_PEND_MASK, .LONG_HIT, .LONG_PEND_MASK,
        .FILTER_EN, .SHORT_ENABLE, .LONG_ENABLE, .ACK_PENDING, .ACK_PENDING_VALID);
    initial forever #2.5 CLK = ~CLK;
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    function automatic logic [31:0] dup(input logic [3:0] v);
        return {24'h0, v[3], v[3], v[2], v[2], v[1], v[1], v[0], v[0]};
    endfunction
    function automatic logic pend(input logic dq);
        return filt & ctl[0] & ctl[1] & (!ctl[2] | dq)
            & (|(SHORT_HIT & {sh[2], sh[1], sh[0]} & SHORT_PEND_MASK)
            | |(LONG_HIT & {lg[2], lg[1], lg[0]} & LONG_PEND_MASK));
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits on pready, never a fixed count
    task apb(input logic w, input logic [29:0] idx, input logic [7:0] d);
        int t;
        @(posedge CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= {idx, 2'b00};
        PWDATA <= {24'h0, d};
        @(posedge CLK);
        PENABLE <= 1;
        t = 0;
        do begin
            @(posedge CLK);
            t++;
        end while (PREADY !== 1'b1 && t < 50);
        if (t >= 50) errors++;
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task rd_chk(input logic [29:0] idx, input logic [31:0] exp);
        apb(0, idx, 8'h00);
        chk(r, exp);
        chk(e, 0);
    endtask
    // one frame pulse; the answer is looked at one cycle later, once settled
    task frame(input logic dq, input logic [23:0] sh_hit, input logic [23:0] sh_pm,
        input logic [11:0] lg_hit, input logic [11:0] lg_pm);
        logic p;
        @(posedge CLK);
        FRAME_VALID <= 1;
        FRAME_IS_DATA_REQ <= dq;
        SHORT_HIT <= sh_hit;
        SHORT_PEND_MASK <= sh_pm;
        LONG_HIT <= lg_hit;
        LONG_PEND_MASK <= lg_pm;
        @(posedge CLK);
        FRAME_VALID <= 0;
        #1;
        p = pend(dq);
        chk(ACK_PENDING_VALID, 1);
        chk(ACK_PENDING, p);
        pc = 8'(pc + 8'(p));
        st = {!filt, |(LONG_HIT & {lg[2], lg[1], lg[0]} & LONG_PEND_MASK),
            |(SHORT_HIT & {sh[2], sh[1], sh[0]} & SHORT_PEND_MASK), p};
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge CLK);
        errors++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge CLK);
        RST_N <= 1;
        rd_chk(IDX_FILTER, 32'h1);
        rd_chk(IDX_CTRL, 32'h7);
        for (k = 0; k < 6; k++) rd_chk(30'(IDX_SHORT0 + k), 32'h0);
        apb(0, 30'h0000_6181, 8'h00);
        chk(r, 32'h0); // unmapped gives zero data
        chk(e, 1); // unmapped gives error
        $display("reset test done");
        for (k = 0; k < 3; k++) begin
            r = rnd();
            sh[k] = r[7:0];
            apb(1, 30'(IDX_SHORT0 + k), sh[k]);
            rd_chk(30'(IDX_SHORT0 + k), {24'h0, sh[k]});
            r = rnd();
            lg[k] = {r[6], r[4], r[2], r[0]};
            apb(1, 30'(IDX_LONG0 + k), r[7:0]);
            rd_chk(30'(IDX_LONG0 + k), dup(lg[k]));
        end
        chk(SHORT_ENABLE, {sh[2], sh[1], sh[0]});
        chk(LONG_ENABLE, {lg[2], lg[1], lg[0]});
        PSTRB <= 4'hE;
        apb(1, IDX_SHORT0, ~sh[0]);
        PSTRB <= 4'hF;
        rd_chk(IDX_SHORT0, {24'h0, sh[0]});
        ctl = 3'h3;
        apb(1, IDX_CTRL, 8'h03);
        rd_chk(IDX_CTRL, 32'h3);
        $display("register test done");
        // sparse one-hot hits so decisions split between set and clear
        for (n = 0; n < 80; n++) begin
            if (n % 8 == 7) begin
                r = rnd();
                ctl = r[2:0];
                filt = r[3];
                apb(1, IDX_CTRL, {5'h00, ctl});
                apb(1, IDX_FILTER, {7'h00, filt});
                #1;
                chk(FILTER_EN, filt);
            end
            r = rnd();
            frame(r[9], 24'h1 << r[4:0], 24'(rnd()), 12'h1 << r[8:5], r[31:20]);
        end
        // a disabled entry must not match after its table slot is rewritten
        filt = 1;
        ctl = 3'h3;
        apb(1, IDX_FILTER, 8'h01);
        apb(1, IDX_CTRL, 8'h03);
        sh[0] = 8'h00;
        apb(1, IDX_SHORT0, 8'h00);
        frame(0, 24'h1, 24'hFF_FFFF, 12'h0, 12'h0);
        lg[0] = 4'h0;
        apb(1, IDX_LONG0, 8'hAA);
        rd_chk(IDX_LONG0, 32'h0);
        frame(0, 24'h0, 24'h0, 12'h1, 12'hFFF);
        sh[0] = 8'h01;
        apb(1, IDX_SHORT0, 8'h01);
        frame(0, 24'h1, 24'h1, 12'h0, 12'h0);
        ctl = 3'h7;
        apb(1, IDX_CTRL, 8'h07);
        frame(0, 24'h1, 24'h1, 12'h0, 12'h0);
        frame(1, 24'h1, 24'h1, 12'h0, 12'h0);
        apb(1, IDX_STATUS, 8'hF0);
        rd_chk(IDX_STATUS, {28'h0, st});
        rd_chk(IDX_COUNT, {24'h0, pc});
        apb(1, IDX_COUNT, 8'h00);
        rd_chk(IDX_COUNT, 32'h0);
        $display("frame test done");
        end_of_test();
    end
endmodule

// file: verilog/pending_decide.sv
// automatic pending-bit decision for one received frame
module pending_decide #(
    parameter int SHORT_N = 24,
    parameter int LONG_N = 12
) (
    input logic clk,
    input logic rst_n,
    input logic frame_valid,
    input logic is_data_req,
    input logic filter_en,
    input logic match_en,
    input logic auto_pending_flag_enable,
    input logic dreq_only,
    input logic [SHORT_N-1:0] short_hit,
    input logic [SHORT_N-1:0] short_en,
    input logic [SHORT_N-1:0] short_pend,
    input logic [LONG_N-1:0] long_hit,
    input logic [LONG_N-1:0] long_en,
    input logic [LONG_N-1:0] long_pend,
    output logic pending_q,
    output logic valid_q,
    output logic short_any_q,
    output logic long_any_q,
    output logic bypass_q
);

    ////////////////////////////////////////////////////////////////////////
    // qualify hits; a disabled entry never matches, even mid-rewrite
    logic short_any;
    logic long_any;
    logic dreq_ok;
    logic gates_ok;
    logic pending_d;

    assign short_any = |(short_hit & short_en & short_pend);
    assign long_any = |(long_hit & long_en & long_pend);
    assign dreq_ok = !dreq_only || is_data_req;
    // match enable only counts while filtering is on
    assign gates_ok = filter_en && match_en && auto_pending_flag_enable;
    assign pending_d = gates_ok && dreq_ok && (short_any || long_any);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
            valid_q <= 1'b0;
            short_any_q <= 1'b0;
            long_any_q <= 1'b0;
            bypass_q <= 1'b0;
        end else begin
            valid_q <= frame_valid;
            if (frame_valid) begin
                pending_q <= pending_d;
                short_any_q <= short_any;
                long_any_q <= long_any;
                bypass_q <= !filter_en;
            end
        end
    end

endmodule

// file: verilog/source_match_auto_pending_flag_enable_ctrl.sv
// apb register bank and pending-bit control for receive source matching
module source_match_auto_pending_flag_enable_ctrl (
    input logic CLK,
    input logic RST_N,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [31:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [3:0] PSTRB,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input logic FRAME_VALID,
    input logic FRAME_IS_DATA_REQ,
    input logic [source_match_pkg::SHORT_ENTRIES-1:0] SHORT_HIT,
    input logic [source_match_pkg::SHORT_ENTRIES-1:0] SHORT_PEND_MASK,
    input logic [source_match_pkg::LONG_ENTRIES-1:0] LONG_HIT,
    input logic [source_match_pkg::LONG_ENTRIES-1:0] LONG_PEND_MASK,
    output logic FILTER_EN,
    output logic [source_match_pkg::SHORT_ENTRIES-1:0] SHORT_ENABLE,
    output logic [source_match_pkg::LONG_ENTRIES-1:0] LONG_ENABLE,
    output logic ACK_PENDING,
    output logic ACK_PENDING_VALID
);
    import source_match_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // byte packing of the long enable word
    function automatic logic [LONG_PER_BYTE-1:0] take_even(input logic [7:0] b);
        logic [LONG_PER_BYTE-1:0] r;
        r = '0;
        for (int n = 0; n < LONG_PER_BYTE; n++) begin
            r[n] = b[2*n];
        end
        return r;
    endfunction

    function automatic logic [7:0] spread_pairs(input logic [LONG_PER_BYTE-1:0] e);
        logic [7:0] r;
        r = 8'h00;
        for (int n = 0; n < LONG_PER_BYTE; n++) begin
            r[2*n] = e[n];
            r[2*n+1] = e[n];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic filter_en_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [SHORT_ENTRIES-1:0] short_en_q;
    logic [SHORT_ENTRIES-1:0] short_en_d;
    logic [LONG_ENTRIES-1:0] long_en_q;
    logic [LONG_ENTRIES-1:0] long_en_d;
    logic [ST_W-1:0] status_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [31:0] prdata_q;
    logic pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // apb phase and address decode
    logic setup;
    logic access;
    logic [29:0] idx;
    logic aligned;
    logic hit_filter;
    logic hit_ctrl;
    logic hit_short0;
    logic hit_short1;
    logic hit_short2;
    logic hit_long0;
    logic hit_long1;
    logic hit_long2;
    logic hit_status;
    logic hit_count;
    logic mapped;
    logic wr_ok;

    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign idx = PADDR[31:2];
    assign aligned = (PADDR[1:0] == 2'h0);
    assign hit_filter = aligned && (idx == IDX_FILTER);
    assign hit_ctrl = aligned && (idx == IDX_CTRL);
    assign hit_short0 = aligned && (idx == IDX_SHORT0);
    assign hit_short1 = aligned && (idx == IDX_SHORT1);
    assign hit_short2 = aligned && (idx == IDX_SHORT2);
    assign hit_long0 = aligned && (idx == IDX_LONG0);
    assign hit_long1 = aligned && (idx == IDX_LONG1);
    assign hit_long2 = aligned && (idx == IDX_LONG2);
    assign hit_status = aligned && (idx == IDX_STATUS);
    assign hit_count = aligned && (idx == IDX_COUNT);
    assign mapped = hit_filter || hit_ctrl || hit_short0 || hit_short1 || hit_short2
        || hit_long0 || hit_long1 || hit_long2 || hit_status || hit_count;
    // only the low lane holds data; upper lanes are ignored
    assign wr_ok = access && PWRITE && PSTRB[0];

    ////////////////////////////////////////////////////////////////////////
    // write strobes
    logic we_filter;
    logic we_ctrl;
    logic we_short0;
    logic we_short1;
    logic we_short2;
    logic we_long0;
    logic we_long1;
    logic we_long2;
    logic we_count;

    assign we_filter = wr_ok && hit_filter;
    assign we_ctrl = wr_ok && hit_ctrl;
    assign we_short0 = wr_ok && hit_short0;
    assign we_short1 = wr_ok && hit_short1;
    assign we_short2 = wr_ok && hit_short2;
    assign we_long0 = wr_ok && hit_long0;
    assign we_long1 = wr_ok && hit_long1;
    assign we_long2 = wr_ok && hit_long2;
    assign we_count = wr_ok && hit_count;

    ////////////////////////////////////////////////////////////////////////
    // next values of the writable registers
    // bits 7:3 of control are not stored, so a stray one there has no effect
    assign ctrl_d = we_ctrl ? PWDATA[CTRL_W-1:0] : ctrl_q;

    always_comb begin
        short_en_d = short_en_q;
        if (we_short0) begin
            short_en_d[7:0] = PWDATA[7:0];
        end
        if (we_short1) begin
            short_en_d[15:8] = PWDATA[7:0];
        end
        if (we_short2) begin
            short_en_d[23:16] = PWDATA[7:0];
        end
    end

    always_comb begin
        long_en_d = long_en_q;
        if (we_long0) begin
            long_en_d[3:0] = take_even(PWDATA[7:0]);
        end
        if (we_long1) begin
            long_en_d[7:4] = take_even(PWDATA[7:0]);
        end
        if (we_long2) begin
            long_en_d[11:8] = take_even(PWDATA[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data selection
    logic [7:0] rd_val;

    assign rd_val =
        hit_filter ? {7'h00, filter_en_q} :
        hit_ctrl ? {5'h00, ctrl_q} :
        hit_short0 ? short_en_q[7:0] :
        hit_short1 ? short_en_q[15:8] :
        hit_short2 ? short_en_q[23:16] :
        hit_long0 ? spread_pairs(long_en_q[3:0]) :
        hit_long1 ? spread_pairs(long_en_q[7:4]) :
        hit_long2 ? spread_pairs(long_en_q[11:8]) :
        hit_status ? {4'h0, status_q} :
        hit_count ? count_q :
        8'h00;

    ////////////////////////////////////////////////////////////////////////
    // control and enable registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            filter_en_q <= FILTER_RST;
            ctrl_q <= CTRL_RST;
        end else begin
            if (we_filter) begin
                filter_en_q <= PWDATA[FILTER_EN_BIT];
            end
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            short_en_q <= {3{MASK_RST}};
            long_en_q <= '0;
        end else begin
            short_en_q <= short_en_d;
            long_en_q <= long_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states, data captured in the setup cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= {24'h00_0000, rd_val};
            pslverr_q <= !mapped;
        end
    end

    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = access && pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // pending decision
    logic dec_pending;
    logic dec_valid;
    logic dec_short;
    logic dec_long;
    logic dec_bypass;

    pending_decide #(
        .SHORT_N(SHORT_ENTRIES),
        .LONG_N(LONG_ENTRIES)
    ) u_decide (
        .clk(CLK),
        .rst_n(RST_N),
        .frame_valid(FRAME_VALID),
        .is_data_req(FRAME_IS_DATA_REQ),
        .filter_en(filter_en_q),
        .match_en(ctrl_q[MATCH_EN_BIT]),
        .auto_pending_flag_enable(ctrl_q[AUTO_PENDING_BIT]),
        .dreq_only(ctrl_q[DREQ_ONLY_BIT]),
        .short_hit(SHORT_HIT),
        .short_en(short_en_q),
        .short_pend(SHORT_PEND_MASK),
        .long_hit(LONG_HIT),
        .long_en(long_en_q),
        .long_pend(LONG_PEND_MASK),
        .pending_q(dec_pending),
        .valid_q(dec_valid),
        .short_any_q(dec_short),
        .long_any_q(dec_long),
        .bypass_q(dec_bypass)
    );

    ////////////////////////////////////////////////////////////////////////
    // status of the last decision and count of pending answers
    // a pending decision in the clearing cycle still counts
    always_comb begin
        count_d = count_q;
        if (we_count) begin
            count_d = 8'h00;
        end
        if (dec_valid && dec_pending) begin
            count_d = we_count ? 8'h01 : 8'(count_q + 8'h01);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            status_q <= STATUS_RST;
            count_q <= COUNT_RST;
        end else begin
            count_q <= count_d;
            if (dec_valid) begin
                status_q[ST_PENDING_BIT] <= dec_pending;
                status_q[ST_SHORT_BIT] <= dec_short;
                status_q[ST_LONG_BIT] <= dec_long;
                status_q[ST_BYPASS_BIT] <= dec_bypass;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward the filter, match engine and ack generator
    assign FILTER_EN = filter_en_q;
    assign SHORT_ENABLE = short_en_q;
    assign LONG_ENABLE = long_en_q;
    assign ACK_PENDING = dec_pending;
    assign ACK_PENDING_VALID = dec_valid;

endmodule
